//--- rui_pkg.sv
// Constants, field layouts and types shared by the start-up interface loader
package rui_pkg;

  // Clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int HOLD_TIME_S = 5;
  localparam int PULSE_TIME_MS = 30;
  localparam logic [31:0] HOLD_CYC = 32'(HOLD_TIME_S * CLK_HZ);
  localparam logic [31:0] PULSE_CYC = 32'(PULSE_TIME_MS * (CLK_HZ / 1000));
  localparam int SLOW_SHIFT = 2;

  // System defaults applied until the host acknowledges
  localparam logic [7:0] REPORT_RATE_MS = 8'h96;
  localparam logic [7:0] RDY_TIMEOUT_MS = 8'h1E;
  localparam logic [7:0] HALT_TIME_S = 8'h28;

  // Wake channel defaults
  localparam logic [7:0] WAKE_BASE = 8'h64;
  localparam logic [9:0] WAKE_TARGET = 10'h240;
  localparam logic [7:0] WAKE_PROX = 8'h08;
  localparam logic [3:0] WAKE_HYST_IDX = 4'h5;
  localparam logic [1:0] PRESC_QUARTER = 2'h2;
  localparam logic [7:0] PAD_ZERO_MASK = 8'h01;
  localparam logic [7:0] PAD_GROUP_MASK = 8'hF4;
  localparam logic [7:0] WAKE_THR_0 = 8'h10;
  localparam logic [7:0] WAKE_THR_1 = 8'h04;
  localparam logic [7:0] WAKE_THR_2 = 8'h08;
  localparam logic [7:0] WAKE_THR_3 = 8'h20;
  localparam int LTA_SCALE_SHIFT = 8;

  // Magnetic channel figures
  localparam logic [9:0] MAG_TARGET_BASE = 10'h1A0;
  localparam int MAG_TARGET_STEP_SHIFT = 7;
  localparam logic [7:0] MAG_THR_OFFSET = 8'h03;
  localparam logic [8:0] MAG_CS_OFFSET = 9'h001;

  // Address selection
  localparam logic [6:0] I2C_ADDR_BASE = 7'h44;
  localparam logic [6:0] I2C_ADDR_SEL = 7'h01;
  localparam logic [6:0] I2C_ADDR_STRAP = 7'h02;

  // Field positions in the programmable bytes
  localparam int OUT_STYLE_POS = 0;
  localparam int RDY_STYLE_POS = 1;
  localparam int ADDR_SEL_POS = 2;
  localparam int OSC_SEL_POS = 3;
  localparam int PAD_GROUP_POS = 4;
  localparam int IF_SEL_LSB = 0;
  localparam int WAKE_THR_LSB = 2;
  localparam int MAG_TGT_LSB = 0;
  localparam int MAG_THR_LSB = 0;

  // Register offsets
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_WAKE_THR = 8'h11;
  localparam logic [7:0] OFS_MAG_THR = 8'h12;
  localparam logic [7:0] OFS_MAG_TGT = 8'h13;
  localparam logic [7:0] OFS_PIN_CTRL = 8'h14;
  localparam logic [7:0] OFS_REPORT = 8'h15;
  localparam logic [7:0] OFS_TEMP_COUNTS = 8'h21;
  localparam logic [7:0] OFS_TEMP_REF = 8'h22;
  localparam int ACK_POS = 0;
  localparam int AUTO_PM_POS = 1;
  localparam int RELEASE_POS = 0;

  typedef enum logic [1:0] {UI_ONE, UI_TWO, UI_THREE, UI_FOUR} ui_t;
  typedef enum logic {ST_LOAD, ST_RUN} load_state_t;

endpackage : rui_pkg

//--- pin_driver.sv
// Registered pin driver for push-pull or open-drain output styles
`timescale 1ns/1ps
module pin_driver (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic drive_en,
  input wire logic active,
  input wire logic push_pull,
  // Pin
  output logic pin_out,
  output logic pin_oe_n
);

  typedef struct packed {
    logic out;
    logic oe_n;
  } drv_t;

  drv_t st_r;
  drv_t st_nxt;

  // Push-pull drives the level; open-drain pulls low only when active
  always_comb begin
    st_nxt.out = 1'b0;
    st_nxt.oe_n = 1'b1;
    if (drive_en && push_pull) begin
      st_nxt.oe_n = 1'b0;
      st_nxt.out = active;
    end else if (drive_en) begin
      st_nxt.oe_n = ~active;
    end
  end

  // Pin released during reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.out;
  assign pin_oe_n = st_r.oe_n;

endmodule : pin_driver

//--- rui_loader.sv
// Start-up interface loader: decodes programmable bytes and drives standalone pins
//
// What this block does
// - After reset enter one of four interfaces picked by sixth-byte select field.
// - Until host acknowledge: normal power only, 150ms rate, no auto switch, 30ms, 40s.
// - Host port and ready line stay working in every interface.
// - Output pins active-high push-pull, or active-low open-drain when style bit set.
// - Ready line active-low open-drain, or active-high push-pull when its bit set.
// - Address 0x44, or 0x45 when address select bit set.
// - Oscillator 16MHz, or 4MHz when set; hold and pulse times times four then.
// - Interfaces one and two: first pin active while wake channel over threshold.
// - Wake channel loads self-cap defaults at reset; host may change them.
// - Wake channel uses pad zero, or five trackpad pads when group bit set.
// - Wake threshold register loads 16, 4, 8 or 32 from sixth-byte field.
// - After each conversion threshold counts = register / 256 times long-term average.
// - Interface one: second pin active while magnetic channel over threshold.
// - Magnetic tuning target 416, 544, 672 or 800 from fourth-byte field.
// - Magnetic register = 4 times field plus 3; counts = twice register plus one.
// - Compensation on uses adjusted threshold; off uses plain count threshold.
// - Interface one: channel two in temperature mode, counts at 0x21, reference 0x22.
// - Interface two: 5s continuous wake touch gives one 30ms pulse on second pin.
// - Interface three: second pin sampled at reset; low sets address bit 1.
// - Interface four: second pin held active until host reconfigures it.
// - Reset flag reads 1 after any reset until host acknowledges.
`timescale 1ns/1ps
module rui_loader #(
  parameter logic [31:0] HOLD_CYCLES = rui_pkg::HOLD_CYC,
  parameter logic [31:0] PULSE_CYCLES = rui_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Programmable bytes
  input wire logic [7:0] prog_byte_first,
  input wire logic [7:0] prog_byte_fourth,
  input wire logic [7:0] prog_byte_fifth,
  input wire logic [7:0] prog_byte_sixth,
  // Host register port
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [7:0] rd_addr,
  output logic [15:0] rd_data,
  // Sensing engine
  input wire logic conv_done,
  input wire logic [15:0] wake_delta,
  input wire logic [15:0] wake_lta,
  input wire logic [15:0] mag_output,
  input wire logic temp_comp_en,
  input wire logic [15:0] mag_adj_thr,
  input wire logic [15:0] temp_counts,
  input wire logic [15:0] temp_ref,
  input wire logic rdy_req,
  // Standalone pins
  output logic first_pin_out,
  output logic first_pin_oe_n,
  input wire logic second_pin_in,
  output logic second_pin_out,
  output logic second_pin_oe_n,
  output logic rdy_out,
  output logic rdy_oe_n,
  // Decoded settings
  output rui_pkg::ui_t startup_interface,
  output logic [6:0] i2c_addr,
  output logic osc_slow,
  output logic show_reset,
  output logic np_only,
  output logic auto_pm_en,
  output logic [7:0] report_rate_ms,
  output logic [7:0] rdy_timeout_ms,
  output logic [7:0] halt_time_s,
  output logic [7:0] wake_base,
  output logic [9:0] wake_target,
  output logic [7:0] wake_prox,
  output logic [3:0] wake_hyst,
  output logic [1:0] wake_presc,
  output logic [7:0] wake_pad_mask,
  output logic [7:0] wake_thr_reg,
  output logic [15:0] wake_thr_cs,
  output logic mag_en,
  output logic [9:0] mag_target,
  output logic [7:0] mag_thr_reg,
  output logic generic_channel_two_temp_mode
);
  import rui_pkg::*;

  typedef struct packed {
    load_state_t state;
    ui_t ui;
    logic show_reset;
    logic np_only;
    logic auto_pm;
    logic out_od;
    logic rdy_pp;
    logic osc_slow;
    logic [6:0] addr;
    logic [7:0] report;
    logic [7:0] pad_mask;
    logic [7:0] wake_thr;
    logic [15:0] wake_thr_cs;
    logic [9:0] mag_target;
    logic [7:0] mag_thr;
    logic second_force;
    logic wake_act;
    logic mag_act;
    logic hold_done;
    logic pulse_act;
    logic [31:0] hold_cnt;
    logic [31:0] pulse_cnt;
    logic [15:0] rd_data;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic running;
  logic [31:0] hold_limit;
  logic [31:0] pulse_limit;
  logic [23:0] wake_prod;
  logic [8:0] mag_cs;
  logic [15:0] mag_thr_use;
  logic first_en;
  logic second_en;
  logic second_act;

  // Slow oscillator stretches the hold and pulse times by four
  assign hold_limit = st_r.osc_slow ? (HOLD_CYCLES << SLOW_SHIFT) : HOLD_CYCLES;
  assign pulse_limit = st_r.osc_slow ? (PULSE_CYCLES << SLOW_SHIFT) : PULSE_CYCLES;
  assign running = (st_r.state == ST_RUN);

  // Threshold arithmetic
  assign wake_prod = st_r.wake_thr * wake_lta;
  assign mag_cs = {st_r.mag_thr, 1'b0} + MAG_CS_OFFSET;
  assign mag_thr_use = temp_comp_en ? mag_adj_thr : {7'h00, mag_cs};

  // Pin enables; pins stay released until the bytes are decoded
  assign first_en = running && (st_r.ui == UI_ONE || st_r.ui == UI_TWO);
  always_comb begin
    second_en = 1'b0;
    second_act = 1'b0;
    if (running) begin
      case (st_r.ui)
        UI_ONE: begin
          second_en = 1'b1;
          second_act = st_r.mag_act;
        end
        UI_TWO: begin
          second_en = 1'b1;
          second_act = st_r.pulse_act;
        end
        UI_THREE: begin
          second_en = 1'b0;
          second_act = 1'b0;
        end
        UI_FOUR: begin
          second_en = st_r.second_force;
          second_act = 1'b1;
        end
        default: begin
          second_en = 1'b0;
          second_act = 1'b0;
        end
      endcase
    end
  end

  // Next-state logic: load once, then run and serve the host
  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      ST_LOAD: begin
        // Decode programmable bytes; strap pin is sampled only here
        case (prog_byte_sixth[IF_SEL_LSB +: 2])
          2'h0: st_nxt.ui = UI_ONE;
          2'h1: st_nxt.ui = UI_TWO;
          2'h2: st_nxt.ui = UI_THREE;
          default: st_nxt.ui = UI_FOUR;
        endcase
        st_nxt.out_od = prog_byte_first[OUT_STYLE_POS];
        st_nxt.rdy_pp = prog_byte_first[RDY_STYLE_POS];
        st_nxt.osc_slow = prog_byte_first[OSC_SEL_POS];
        st_nxt.addr = I2C_ADDR_BASE;
        if (prog_byte_first[ADDR_SEL_POS]) begin
          st_nxt.addr = I2C_ADDR_BASE | I2C_ADDR_SEL;
        end
        if (prog_byte_sixth[IF_SEL_LSB +: 2] == 2'h2 && !second_pin_in) begin
          st_nxt.addr = st_nxt.addr | I2C_ADDR_STRAP;
        end
        st_nxt.pad_mask = prog_byte_first[PAD_GROUP_POS] ? PAD_GROUP_MASK
                                                          : PAD_ZERO_MASK;
        case (prog_byte_sixth[WAKE_THR_LSB +: 2])
          2'h0: st_nxt.wake_thr = WAKE_THR_0;
          2'h1: st_nxt.wake_thr = WAKE_THR_1;
          2'h2: st_nxt.wake_thr = WAKE_THR_2;
          default: st_nxt.wake_thr = WAKE_THR_3;
        endcase
        st_nxt.mag_target = MAG_TARGET_BASE
          + (10'(prog_byte_fourth[MAG_TGT_LSB +: 2]) << MAG_TARGET_STEP_SHIFT);
        st_nxt.mag_thr = {prog_byte_fifth[MAG_THR_LSB +: 6], 2'b00}
          + MAG_THR_OFFSET;
        st_nxt.second_force = 1'b1;
        st_nxt.state = ST_RUN;
      end
      ST_RUN: begin
        // Threshold in counts follows the average after each conversion
        if (conv_done) begin
          st_nxt.wake_thr_cs = wake_prod[LTA_SCALE_SHIFT +: 16];
        end
        st_nxt.wake_act = (st_r.ui == UI_ONE || st_r.ui == UI_TWO)
          && (wake_delta > st_r.wake_thr_cs);
        st_nxt.mag_act = (st_r.ui == UI_ONE)
          && (mag_output > mag_thr_use);
        // Touch-hold: one pulse per continuous touch, rearmed on release
        if (st_r.ui == UI_TWO && st_r.wake_act) begin
          if (!st_r.hold_done) begin
            if (st_r.hold_cnt >= hold_limit - 32'h1) begin
              st_nxt.hold_done = 1'b1;
              st_nxt.pulse_act = 1'b1;
              st_nxt.pulse_cnt = 32'h0;
            end else begin
              st_nxt.hold_cnt = st_r.hold_cnt + 32'h1;
            end
          end
        end else begin
          st_nxt.hold_cnt = 32'h0;
          st_nxt.hold_done = 1'b0;
        end
        if (st_r.pulse_act) begin
          if (st_r.pulse_cnt >= pulse_limit - 32'h1) begin
            st_nxt.pulse_act = 1'b0;
          end else begin
            st_nxt.pulse_cnt = st_r.pulse_cnt + 32'h1;
          end
        end
        // Host writes stay accepted in every interface
        if (host_wr) begin
          if (host_addr == OFS_FLAGS) begin
            if (host_wdata[ACK_POS]) begin
              st_nxt.show_reset = 1'b0;
              st_nxt.np_only = 1'b0;
            end
            st_nxt.auto_pm = host_wdata[AUTO_PM_POS];
          end else if (host_addr == OFS_WAKE_THR) begin
            st_nxt.wake_thr = host_wdata[7:0];
          end else if (host_addr == OFS_MAG_THR) begin
            st_nxt.mag_thr = host_wdata[7:0];
          end else if (host_addr == OFS_MAG_TGT) begin
            st_nxt.mag_target = host_wdata[9:0];
          end else if (host_addr == OFS_PIN_CTRL) begin
            st_nxt.second_force = ~host_wdata[RELEASE_POS];
          end else if (host_addr == OFS_REPORT) begin
            st_nxt.report = host_wdata[7:0];
          end
        end
      end
      default: begin
        st_nxt.state = ST_LOAD;
      end
    endcase
    // Read data registered one cycle after the address
    if (rd_addr == OFS_FLAGS) begin
      st_nxt.rd_data = {8'h00, st_r.show_reset, st_r.np_only, st_r.auto_pm,
                        3'b000, st_r.ui};
    end else if (rd_addr == OFS_TEMP_COUNTS) begin
      st_nxt.rd_data = temp_counts;
    end else if (rd_addr == OFS_TEMP_REF) begin
      st_nxt.rd_data = temp_ref;
    end else if (rd_addr == OFS_WAKE_THR) begin
      st_nxt.rd_data = {8'h00, st_r.wake_thr};
    end else if (rd_addr == OFS_MAG_THR) begin
      st_nxt.rd_data = {8'h00, st_r.mag_thr};
    end else begin
      st_nxt.rd_data = 16'h0000;
    end
  end

  // State register; reset flags the host and restores system defaults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.state <= ST_LOAD;
      st_r.ui <= UI_ONE;
      st_r.show_reset <= 1'b1;
      st_r.np_only <= 1'b1;
      st_r.auto_pm <= 1'b0;
      st_r.report <= REPORT_RATE_MS;
      st_r.addr <= I2C_ADDR_BASE;
      st_r.pad_mask <= PAD_ZERO_MASK;
      st_r.wake_thr <= WAKE_THR_0;
      st_r.mag_target <= MAG_TARGET_BASE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drivers share one style bit for both standalone outputs
  pin_driver u_first_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .drive_en(first_en),
    .active(st_r.wake_act),
    .push_pull(~st_r.out_od),
    .pin_out(first_pin_out),
    .pin_oe_n(first_pin_oe_n)
  );

  pin_driver u_second_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .drive_en(second_en),
    .active(second_act),
    .push_pull(~st_r.out_od),
    .pin_out(second_pin_out),
    .pin_oe_n(second_pin_oe_n)
  );

  // Ready line works in all interfaces, even before acknowledge
  pin_driver u_ready (
    .clk(clk),
    .sys_rst(sys_rst),
    .drive_en(running),
    .active(rdy_req),
    .push_pull(st_r.rdy_pp),
    .pin_out(rdy_out),
    .pin_oe_n(rdy_oe_n)
  );

  // Settings straight from the state register, plus fixed ready timeout and halt time
  assign startup_interface = st_r.ui;
  assign i2c_addr = st_r.addr;
  assign osc_slow = st_r.osc_slow;
  assign show_reset = st_r.show_reset;
  assign np_only = st_r.np_only;
  assign auto_pm_en = st_r.auto_pm;
  assign report_rate_ms = st_r.report;
  assign rdy_timeout_ms = RDY_TIMEOUT_MS;
  assign halt_time_s = HALT_TIME_S;
  // Fixed wake defaults; host-visible copies live in the sensing engine
  assign wake_base = WAKE_BASE;
  assign wake_target = WAKE_TARGET;
  assign wake_prox = WAKE_PROX;
  assign wake_hyst = WAKE_HYST_IDX;
  assign wake_presc = PRESC_QUARTER;
  assign wake_pad_mask = st_r.pad_mask;
  assign wake_thr_reg = st_r.wake_thr;
  assign wake_thr_cs = st_r.wake_thr_cs;
  assign mag_en = running && (st_r.ui == UI_ONE);
  assign mag_target = st_r.mag_target;
  assign mag_thr_reg = st_r.mag_thr;
  assign generic_channel_two_temp_mode = running && (st_r.ui == UI_ONE);
  assign rd_data = st_r.rd_data;

endmodule : rui_loader

//--- rui_monitor.sv
// Port-level property checker for the start-up interface loader
`timescale 1ns/1ps
module rui_monitor #(
  parameter logic [31:0] HOLD_CYCLES = 32'd50,
  parameter logic [31:0] PULSE_CYCLES = 32'd10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Programmable bytes and strap
  input wire logic [7:0] prog_byte_first,
  input wire logic [7:0] prog_byte_fourth,
  input wire logic [7:0] prog_byte_fifth,
  input wire logic [7:0] prog_byte_sixth,
  input wire logic second_pin_in,
  // Host writes
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  // Sensing inputs
  input wire logic conv_done,
  input wire logic [15:0] wake_delta,
  input wire logic [15:0] wake_lta,
  input wire logic [15:0] mag_output,
  input wire logic temp_comp_en,
  input wire logic rdy_req,
  // Pins
  input wire logic first_pin_out,
  input wire logic first_pin_oe_n,
  input wire logic second_pin_out,
  input wire logic second_pin_oe_n,
  input wire logic rdy_out,
  input wire logic rdy_oe_n,
  // Decoded settings
  input wire rui_pkg::ui_t startup_interface,
  input wire logic [6:0] i2c_addr,
  input wire logic osc_slow,
  input wire logic show_reset,
  input wire logic np_only,
  input wire logic auto_pm_en,
  input wire logic [7:0] report_rate_ms,
  input wire logic [7:0] wake_thr_reg,
  input wire logic [15:0] wake_thr_cs,
  input wire logic [9:0] mag_target,
  input wire logic [7:0] mag_thr_reg
);
  import rui_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic sec_act;
  logic [31:0] pcnt_r;
  logic [31:0] plim;
  logic [7:0] wthr;
  // Second pin active in either style; open drain never drives high
  assign sec_act = !second_pin_oe_n && (second_pin_out || prog_byte_first[0]);
  assign plim = osc_slow ? (PULSE_CYCLES << 2) : PULSE_CYCLES;
  // Expected wake threshold from the sixth byte
  always_comb begin
    case (prog_byte_sixth[3:2])
      2'h0: wthr = 8'h10;
      2'h1: wthr = 8'h04;
      2'h2: wthr = 8'h08;
      default: wthr = 8'h20;
    endcase
  end
  // Length of the current second pin activity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcnt_r <= 32'h0;
    end else begin
      pcnt_r <= sec_act ? pcnt_r + 32'h1 : 32'h0;
    end
  end
  reset_defaults_a: assert property ($fell(sys_rst) |-> show_reset && np_only
      && !auto_pm_en && report_rate_ms == 8'h96) else $error("defaults wrong after reset");
  ack_clear_a: assert property ($fell(show_reset) |-> $past(host_wr)
      && $past(host_addr) == 8'h10 && $past(host_wdata[0])) else $error("flag cleared early");
  addr_pick_a: assert property ($fell(sys_rst) |-> ##2 i2c_addr == (7'h44
      | {6'h0, prog_byte_first[2]} | {5'h0, prog_byte_sixth[1:0] == 2'h2 && !second_pin_in, 1'b0}))
      else $error("address not decoded");
  addr_hold_a: assert property (!$stable(i2c_addr) |-> $past(sys_rst, 3))
      else $error("address changed at runtime");
  wake_load_a: assert property ($fell(sys_rst) |-> ##2 wake_thr_reg == wthr)
      else $error("wake threshold not loaded");
  mag_load_a: assert property ($fell(sys_rst) |-> ##2 mag_thr_reg == {prog_byte_fifth[5:0], 2'b11}
      && mag_target == 10'h1A0 + {1'b0, prog_byte_fourth[1:0], 7'h0}) else $error("magnetic load");
  wake_counts_a: assert property (conv_done |=> wake_thr_cs == 16'(({8'h0, $past(wake_lta)}
      * {16'h0, $past(wake_thr_reg)}) >> 8)) else $error("wake counts threshold wrong");
  first_pin_a: assert property ((startup_interface inside {UI_ONE, UI_TWO}
      && wake_delta > wake_thr_cs)[*5] |-> !first_pin_oe_n && first_pin_out == !prog_byte_first[0])
      else $error("first pin not active on touch");
  mag_pin_a: assert property ((startup_interface == UI_ONE && !temp_comp_en
      && mag_output <= {7'h0, mag_thr_reg, 1'b1})[*5] |-> !sec_act) else $error("magnetic pin on");
  pulse_len_a: assert property (startup_interface == UI_TWO && !sec_act && $past(sec_act)
      |-> pcnt_r == plim) else $error("hold pulse length wrong");
  forced_pin_a: assert property (startup_interface == UI_FOUR && $fell(sec_act)
      |-> ($past(host_wr) && $past(host_addr) == 8'h14) || ($past(host_wr, 2)
      && $past(host_addr, 2) == 8'h14)) else $error("forced pin dropped");
  ready_style_a: assert property (rdy_req[*5] |-> !rdy_oe_n && rdy_out == prog_byte_first[1])
      else $error("ready level wrong");
  pulse_seen_c: cover property (startup_interface == UI_TWO && $rose(sec_act));
  strap_low_c: cover property ($fell(sys_rst) ##2 i2c_addr[1]);
  forced_on_c: cover property (startup_interface == UI_FOUR && sec_act);
endmodule : rui_monitor

bind rui_loader rui_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) mon (.*);

//--- host_model.sv
// Host controller model issuing register writes and reads
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic host_wr,
  output logic [7:0] host_addr,
  output logic [15:0] host_wdata,
  output logic [7:0] rd_addr,
  input wire logic [15:0] rd_data
);
  // Idle values at time zero
  initial begin
    host_wr = 1'b0;
    host_addr = 8'hFF;
    host_wdata = 16'h0000;
    rd_addr = 8'hFF;
  end
  // One-cycle strobe; address and data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~d;
  endtask : wr
  // Read data is registered, so taken two edges after the address
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    rd_addr <= a;
    @(posedge clk);
    @(posedge clk);
    d = rd_data;
    rd_addr <= ~a;
  endtask : rd
endmodule : host_model

//--- tb_rui_loader.sv
// Self-checking bench for the start-up interface loader
`timescale 1ns/1ps
module tb_rui_loader;
  import rui_pkg::*;
  // Short timers keep the run brief
  localparam logic [31:0] HOLD_N = 32'd50;
  localparam logic [31:0] PULSE_N = 32'd10;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] prog_byte_first = 8'h00, prog_byte_fourth = 8'h00;
  logic [7:0] prog_byte_fifth = 8'h00, prog_byte_sixth = 8'h00;
  logic host_wr, conv_done = 1'b0, temp_comp_en = 1'b0, rdy_req = 1'b0, second_pin_in = 1'b1;
  logic [7:0] host_addr, rd_addr;
  logic [15:0] host_wdata, rd_data, wake_delta = 16'h0, wake_lta = 16'h0, mag_output = 16'h0;
  logic [15:0] mag_adj_thr = 16'h0, temp_counts = 16'hA5C3, temp_ref = 16'h3C5A, d;
  logic first_pin_out, first_pin_oe_n, second_pin_out, second_pin_oe_n, rdy_out, rdy_oe_n;
  ui_t startup_interface;
  logic [6:0] i2c_addr;
  logic osc_slow, show_reset, np_only, auto_pm_en, mag_en, generic_channel_two_temp_mode;
  logic [7:0] report_rate_ms, rdy_timeout_ms, halt_time_s, wake_base, wake_prox;
  logic [7:0] wake_pad_mask, wake_thr_reg, mag_thr_reg;
  logic [9:0] wake_target, mag_target;
  logic [3:0] wake_hyst;
  logic [1:0] wake_presc;
  logic [15:0] wake_thr_cs;
  int num_errors = 0;
  int checked = 0;
  int t, n;

  // Every port has a bench signal of the same name
  rui_loader #(.HOLD_CYCLES(HOLD_N), .PULSE_CYCLES(PULSE_N)) dut (.*);
  host_model host (.clk, .host_wr, .host_addr, .host_wdata, .rd_addr, .rd_data);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Reset with new byte values; returns once the pins drive
  task automatic boot(input logic [7:0] f, input logic [7:0] p4, input logic [7:0] p5,
                      input logic [7:0] p6, input logic s);
    @(posedge clk);
    sys_rst <= 1'b1;
    prog_byte_first <= f;
    prog_byte_fourth <= p4;
    prog_byte_fifth <= p5;
    prog_byte_sixth <= p6;
    second_pin_in <= s;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    step(4);
  endtask : boot

  task automatic conv(input logic [15:0] long_term_average);
    @(posedge clk);
    wake_lta <= long_term_average;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    step(2);
  endtask : conv

  task automatic pins(input logic [15:0] w, input logic [15:0] m);
    @(posedge clk);
    wake_delta <= w;
    mag_output <= m;
    step(3);
  endtask : pins

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    // Interface one with every byte clear
    boot(8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
    chk(startup_interface, UI_ONE);
    chk({show_reset, np_only, auto_pm_en, osc_slow}, 4'hC);
    chk({report_rate_ms, rdy_timeout_ms}, 16'h961E);
    chk(halt_time_s, 8'h28);
    chk(i2c_addr, 7'h44);
    chk({wake_base, wake_prox}, 16'h6408);
    chk({wake_hyst, wake_presc, wake_target}, 16'h5A40);
    chk({wake_pad_mask, wake_thr_reg}, 16'h0110);
    chk({mag_target, mag_thr_reg[5:0]}, 16'h6803);
    chk({mag_en, generic_channel_two_temp_mode}, 2'h3);
    host.rd(OFS_TEMP_COUNTS, d);
    chk(d, 16'hA5C3);
    host.rd(OFS_TEMP_REF, d);
    chk(d, 16'h3C5A);
    host.rd(8'h30, d);
    chk(d, 16'h0000);
    host.rd(OFS_FLAGS, d);
    chk(d, 16'h00C0);
    // Touch thresholds at their boundaries
    conv(16'h0100);
    chk(wake_thr_cs, 16'h0010);
    pins(16'h0011, 16'h0008);
    chk({first_pin_oe_n, first_pin_out, second_pin_oe_n, second_pin_out}, 4'h5);
    pins(16'h0010, 16'h0007);
    chk({first_pin_oe_n, first_pin_out, second_pin_oe_n, second_pin_out}, 4'h0);
    conv(16'h0200);
    pins(16'h0011, 16'h0000);
    chk({wake_thr_cs[14:0], first_pin_out}, 16'h0040);
    @(posedge clk);
    temp_comp_en <= 1'b1;
    mag_adj_thr <= 16'h0064;
    pins(16'h0000, 16'h0064);
    chk(second_pin_out, 1'b0);
    pins(16'h0000, 16'h0065);
    chk(second_pin_out, 1'b1);
    @(posedge clk);
    rdy_req <= 1'b1;
    step(3);
    chk({rdy_oe_n, rdy_out}, 2'b00);
    @(posedge clk);
    rdy_req <= 1'b0;
    step(3);
    chk(rdy_oe_n, 1'b1);
    // Host rewrites settings and acknowledges
    host.wr(OFS_WAKE_THR, 16'h0040);
    host.wr(OFS_REPORT, 16'h0020);
    host.wr(OFS_FLAGS, 16'h0001);
    step(2);
    chk({wake_thr_reg, report_rate_ms}, 16'h4020);
    chk({show_reset, np_only}, 2'b00);
    // Interface two, every option bit set, slow oscillator
    boot(8'h1F, 8'h03, 8'h3F, 8'h0D, 1'b1);
    chk(startup_interface, UI_TWO);
    chk({i2c_addr, osc_slow}, 8'h8B);
    chk({wake_pad_mask, wake_thr_reg}, 16'hF420);
    chk({mag_target, mag_thr_reg[5:0]}, 16'hC83F);
    @(posedge clk);
    rdy_req <= 1'b1;
    conv(16'h0100);
    chk({rdy_oe_n, rdy_out}, 2'b01);
    pins(16'h0040, 16'h0000);
    chk({first_pin_oe_n, first_pin_out}, 2'b00);
    for (t = 0; t < 400 && second_pin_oe_n === 1'b1; t++) begin
      step(1);
    end
    chk(16'(t > 188 && t < 214), 16'h0001);
    if (t == 400) begin
      report_and_stop();
    end
    for (n = 0; n < 100 && second_pin_oe_n === 1'b0; n++) begin
      step(1);
    end
    chk(16'(n), 16'(PULSE_N * 4));
    n = 0;
    for (t = 0; t < 300; t++) begin
      step(1);
      if (second_pin_oe_n !== 1'b1) begin
        n++;
      end
    end
    chk(16'(n), 16'h0000);
    // Interface three: address select and strap in all combinations
    for (int i = 0; i < 4; i++) begin
      boot({5'h0, i[0], 2'h0}, 8'h00, 8'h00, 8'h02, i[1]);
      chk({i2c_addr, second_pin_oe_n}, {7'h44 | {6'h0, i[0]} | {5'h0, !i[1], 1'b0}, 1'b1});
    end
    @(posedge clk);
    second_pin_in <= 1'b0;
    prog_byte_first <= 8'h00;
    step(3);
    chk(i2c_addr, 7'h45);
    // Interface four: forced pin until released by the host
    boot(8'h00, 8'h00, 8'h00, 8'h03, 1'b1);
    chk({second_pin_oe_n, second_pin_out}, 2'b01);
    step(20);
    chk({second_pin_oe_n, second_pin_out}, 2'b01);
    host.wr(OFS_PIN_CTRL, 16'h0001);
    step(3);
    chk(second_pin_out && !second_pin_oe_n, 1'b0);
    report_and_stop();
  end
endmodule : tb_rui_loader
